// ---- core/sswx_pkg.sv ----
// Shared constants and types of the subtract, swap and xor datapath
package sswx_pkg;
	// Data and instruction widths
	localparam int SSWX_DW = 8;
	localparam int SSWX_IW = 14;
	localparam int SSWX_FAW = 7;

	// Instruction word fields
	localparam int SSWX_OPC_HI = 13;
	localparam int SSWX_OPC_LO = 8;
	localparam int SSWX_DEST_BIT = 7;
	localparam int SSWX_FADDR_HI = 6;
	localparam int SSWX_LIT_HI = 7;
	localparam int SSWX_NIB_HI = 3;
	localparam int SSWX_NIB_W = 4;

	// Upper six bits of each handled instruction
	localparam logic [5:0] SSWX_OPC_SUB = 6'h02;
	localparam logic [5:0] SSWX_OPC_SWAP = 6'h0E;
	localparam logic [5:0] SSWX_OPC_XOR = 6'h3A;

	// Operation selected by the decoder
	typedef enum logic [1:0] {
		SSWX_OP_NONE = 2'b00,
		SSWX_OP_SUB = 2'b01,
		SSWX_OP_SWAP = 2'b10,
		SSWX_OP_XOR = 2'b11
	} sswx_op_t;

	// Register byte offsets on the bus
	localparam logic [7:0] SSWX_ACC_OFS = 8'h00;
	localparam logic [7:0] SSWX_STATUS_OFS = 8'h04;
	localparam logic [7:0] SSWX_OPERAND_OFS = 8'h08;
	localparam logic [7:0] SSWX_ISSUE_OFS = 8'h0C;
	localparam logic [7:0] SSWX_RESULT_OFS = 8'h10;
	localparam logic [7:0] SSWX_COUNT_OFS = 8'h14;
	localparam int SSWX_DEC_HI = 7;

	// Status register bit positions
	localparam int SSWX_ST_CARRY = 0;
	localparam int SSWX_ST_NIBBLE = 1;
	localparam int SSWX_ST_ZERO = 2;
	localparam int SSWX_ST_UNSUP = 3;
	localparam int SSWX_ST_PEND = 4;

	// Result register: destination bit above the data byte
	localparam int SSWX_RES_DEST = 8;
	localparam int SSWX_CNT_W = 16;

	// Reset values
	localparam logic [7:0] SSWX_ACC_RST = 8'h00;
	localparam logic [7:0] SSWX_OPERAND_RST = 8'h00;
	localparam logic [13:0] SSWX_ISSUE_RST = 14'h0000;
	localparam logic [15:0] SSWX_CNT_RST = 16'h0000;

	// AHB transfer types and response
	localparam logic [1:0] SSWX_HTRANS_NONSEQ = 2'b10;
	localparam logic SSWX_HRESP_OKAY = 1'b0;

	// Map an instruction word to the operation it asks for
	function automatic sswx_op_t sswx_decode(input logic [SSWX_IW-1:0] word);
		logic [5:0] opc;
		opc = word[SSWX_OPC_HI:SSWX_OPC_LO];
		if (opc == SSWX_OPC_SUB) begin
			return SSWX_OP_SUB;
		end else if (opc == SSWX_OPC_SWAP) begin
			return SSWX_OP_SWAP;
		end else if (opc == SSWX_OPC_XOR) begin
			return SSWX_OP_XOR;
		end
		return SSWX_OP_NONE;
	endfunction : sswx_decode
endpackage : sswx_pkg

// ---- core/sswx_alu.sv ----
// Combinational arithmetic of the three instructions
`timescale 1ns/1ps
`default_nettype none
module sswx_alu
	import sswx_pkg::*;
(
	input wire logic [SSWX_IW-1:0] word_i,
	input wire logic [SSWX_DW-1:0] acc_i,
	input wire logic [SSWX_DW-1:0] file_i,
	output sswx_op_t op_o,
	output logic [SSWX_DW-1:0] result_o,
	output logic carry_o,
	output logic nibble_o,
	output logic zero_o,
	output logic to_acc_o,
	output logic to_file_o,
	output logic upd_cdz_o,
	output logic upd_z_o
);
	logic [SSWX_DW:0] diff;
	logic [SSWX_NIB_W:0] nib_diff;
	logic dest;

	// Nine and five bit differences expose the borrow out of each width
	assign diff = {1'b0, file_i} - {1'b0, acc_i};
	assign nib_diff = {1'b0, file_i[SSWX_NIB_HI:0]} - {1'b0, acc_i[SSWX_NIB_HI:0]};
	assign dest = word_i[SSWX_DEST_BIT];
	assign op_o = sswx_decode(word_i);

	// Operation select; unknown words produce no write and no flag change
	always_comb begin
		result_o = '0;
		to_acc_o = 1'b0;
		to_file_o = 1'b0;
		upd_cdz_o = 1'b0;
		upd_z_o = 1'b0;
		unique case (op_o)
			SSWX_OP_SUB: begin
				result_o = diff[SSWX_DW-1:0]; // [RULE1]
				to_acc_o = ~dest; // [RULE1]
				to_file_o = dest; // [RULE1]
				upd_cdz_o = 1'b1;
			end
			SSWX_OP_SWAP: begin
				result_o = {file_i[SSWX_NIB_HI:0], file_i[SSWX_DW-1:SSWX_NIB_W]}; // [RULE6]
				to_acc_o = ~dest; // [RULE6]
				to_file_o = dest; // [RULE6]
			end
			SSWX_OP_XOR: begin
				result_o = acc_i ^ word_i[SSWX_LIT_HI:0]; // [RULE4]
				to_acc_o = 1'b1; // [RULE5]
				upd_z_o = 1'b1; // [RULE5]
			end
			SSWX_OP_NONE: begin
				result_o = '0;
			end
		endcase
	end

	// No borrow means the carry reads 1, including an exact zero difference
	assign carry_o = ~diff[SSWX_DW]; // [RULE2] [RULE3]
	assign nibble_o = ~nib_diff[SSWX_NIB_W];
	assign zero_o = (result_o == '0);
endmodule : sswx_alu
`default_nettype wire

// ---- core/sswx_top.sv ----
// Datapath top: decoder port, AHB-Lite registers and flag state
//
// Added by the designer: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Operation
// RULE1 - Subtract accumulator from file, target bit selects
// RULE2 - Positive difference sets borrow-inverse carry flag
// RULE3 - Zero difference keeps carry set, stores zero
// RULE4 - Xor accumulator with instruction low byte literal
// RULE5 - Xor result to accumulator, only zero flag
// RULE6 - Swap file nibbles, target bit selects, no flags
module sswx_top
	import sswx_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	// AHB-Lite slave
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	// Instruction port from the core decoder
	input wire logic instr_valid_i,
	input wire logic [SSWX_IW-1:0] instr_i,
	input wire logic [SSWX_DW-1:0] file_rdata_i,
	// File register write-back and flag view
	output logic file_we_o,
	output logic [SSWX_FAW-1:0] file_addr_o,
	output logic [SSWX_DW-1:0] file_wdata_o,
	output logic [SSWX_DW-1:0] acc_o,
	output logic carry_o,
	output logic nibble_borrow_flag_o,
	output logic zero_o,
	output logic done_o
);
	// Bus data phase state
	// Captured at the address phase edge, used for one data phase cycle
	logic dp_write;
	logic dp_read;
	logic [SSWX_DEC_HI:0] dp_addr;
	logic addr_take;

	// Architectural and software-visible state
	// The result register is one bit wider to keep the destination with it
	logic [SSWX_DW-1:0] acc;
	logic carry;
	logic nibble_flag;
	logic zero;
	logic unsup;
	logic [SSWX_DW-1:0] operand;
	logic [SSWX_IW-1:0] issue_word;
	logic issue_pend;
	logic [SSWX_DW:0] result;
	logic [SSWX_CNT_W-1:0] count;

	// Execution select
	// exec is high in every cycle that consumes a word, from either source
	logic sel_port;
	logic sel_bus;
	logic exec;
	logic [SSWX_IW-1:0] exec_word;
	logic [SSWX_DW-1:0] exec_file;

	// Arithmetic outputs
	sswx_op_t alu_op;
	logic [SSWX_DW-1:0] alu_res;
	logic alu_c;
	logic alu_dc;
	logic alu_z;
	logic alu_to_acc;
	logic alu_to_file;
	logic alu_upd_cdz;
	logic alu_upd_z;

	// Software write strobes, valid in the data phase
	// hwdata is only defined in the data phase, so the strobes qualify it
	logic wr_acc;
	logic wr_status;
	logic wr_operand;
	logic wr_issue;

	// Zero-wait slave, so the bus ready output is tied high
	// Every register answers in the data phase, hence no wait state and no
	// error response is ever needed
	assign hreadyout_o = 1'b1;
	assign hresp_o = SSWX_HRESP_OKAY;
	assign addr_take = hsel_i & hready_i & (htrans_i == SSWX_HTRANS_NONSEQ);

	// Address phase capture; hsize is ignored since only words are used
	// A byte or halfword write lands as a whole word, so software keeps to
	// word accesses; only the low address byte is decoded, so the register
	// set repeats through the slave's address window
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dp_write <= 1'b0;
			dp_read <= 1'b0;
			dp_addr <= '0;
		end else if (hready_i) begin
			dp_write <= addr_take & hwrite_i;
			dp_read <= addr_take & ~hwrite_i;
			dp_addr <= haddr_i[SSWX_DEC_HI:0];
		end
	end

	// Offset decode of the write data phase
	// Writes to unmapped or read-only offsets fall through and are ignored
	assign wr_acc = dp_write & (dp_addr == SSWX_ACC_OFS);
	assign wr_status = dp_write & (dp_addr == SSWX_STATUS_OFS);
	assign wr_operand = dp_write & (dp_addr == SSWX_OPERAND_OFS);
	assign wr_issue = dp_write & (dp_addr == SSWX_ISSUE_OFS);

	// Read mux over flops; unmapped offsets read zero
	// Map, byte offsets from the slave base, one word each:
	//   0x00 accumulator, read and write, bits 7:0
	//   0x04 status: carry, nibble borrow, zero, unhandled word, issue pending
	//   0x08 operand, read and write, file register of bus-issued words
	//   0x0C issue word, read and write, a write queues the word
	//   0x10 last result, bit 8 set when it went to the file side
	//   0x14 count of executed words, wraps silently
	// Status bit 3 clears on a written one; bit 4 is read only
	// Upper bits of every word read zero, so software may mask freely
	// The mux is only open while dp_read stands, which keeps idle bus
	// cycles quiet on a shared read data bus
	always_comb begin
		hrdata_o = '0;
		if (dp_read) begin
			unique case (dp_addr)
				SSWX_ACC_OFS: hrdata_o[SSWX_DW-1:0] = acc;
				SSWX_STATUS_OFS: begin
					hrdata_o[SSWX_ST_CARRY] = carry;
					hrdata_o[SSWX_ST_NIBBLE] = nibble_flag;
					hrdata_o[SSWX_ST_ZERO] = zero;
					hrdata_o[SSWX_ST_UNSUP] = unsup;
					hrdata_o[SSWX_ST_PEND] = issue_pend;
				end
				SSWX_OPERAND_OFS: hrdata_o[SSWX_DW-1:0] = operand;
				SSWX_ISSUE_OFS: hrdata_o[SSWX_IW-1:0] = issue_word;
				SSWX_RESULT_OFS: hrdata_o[SSWX_DW:0] = result;
				SSWX_COUNT_OFS: hrdata_o[SSWX_CNT_W-1:0] = count;
				default: hrdata_o = '0;
			endcase
		end
	end

	// The decoder port always wins; a bus-issued word waits for a free cycle
	// A busy core can therefore starve a queued word; software polls the
	// pending bit in status before it trusts the result register
	// The queued word reads its file operand from the operand register and
	// writes back there, so the core's file array never sees a bus write
	// An unhandled word still costs a cycle and raises done
	// Timing for the port, per instruction:
	//   edge N     word and file value sampled, accumulator and flags load
	//   cycle N+1  write strobe and done stand for one cycle; address and data hold after it
	//   edge N+1   the file array takes the write-back
	// Back-to-back words are legal; the second reads the new accumulator
	assign sel_port = instr_valid_i;
	assign sel_bus = issue_pend & ~instr_valid_i;
	assign exec = sel_port | sel_bus;
	assign exec_word = sel_port ? instr_i : issue_word;
	assign exec_file = sel_port ? file_rdata_i : operand;

	// Shared arithmetic for both word sources
	sswx_alu u_alu (
		.word_i(exec_word),
		.acc_i(acc),
		.file_i(exec_file),
		.op_o(alu_op),
		.result_o(alu_res),
		.carry_o(alu_c),
		.nibble_o(alu_dc),
		.zero_o(alu_z),
		.to_acc_o(alu_to_acc),
		.to_file_o(alu_to_file),
		.upd_cdz_o(alu_upd_cdz),
		.upd_z_o(alu_upd_z)
	);

	// Accumulator: an executing instruction beats a software write
	// A software write that collides with an executing word that targets the accumulator is lost without
	// trace; the trade keeps the datapath free of a stall path to the bus
	// Software that must not race the core writes only while it is idle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			acc <= SSWX_ACC_RST;
		end else if (exec && alu_to_acc) begin
			acc <= alu_res; // [RULE1] [RULE4] [RULE5] [RULE6]
		end else if (wr_acc) begin
			acc <= hwdata_i[SSWX_DW-1:0];
		end
	end

	// Carry and nibble borrow move only on a subtract or a status write
	// Both read as no borrow: 1 when the minuend is at least the subtrahend,
	// which also covers an exact zero difference
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			carry <= 1'b0;
			nibble_flag <= 1'b0;
		end else if (exec && alu_upd_cdz) begin
			carry <= alu_c; // [RULE2] [RULE3]
			nibble_flag <= alu_dc;
		end else if (wr_status) begin
			carry <= hwdata_i[SSWX_ST_CARRY];
			nibble_flag <= hwdata_i[SSWX_ST_NIBBLE];
		end
	end

	// Zero flag follows subtract and xor, never the swap
	// Swap leaves all three flags alone, so software may rely on them
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			zero <= 1'b0;
		end else if (exec && (alu_upd_cdz || alu_upd_z)) begin
			zero <= alu_z; // [RULE3] [RULE5]
		end else if (wr_status) begin
			zero <= hwdata_i[SSWX_ST_ZERO];
		end
	end

	// Sticky mark of an unhandled word; write one clears, a new set wins
	// Giving the set priority means a clear racing a fresh unhandled word
	// never hides that word from software
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			unsup <= 1'b0;
		end else if (exec && alu_op == SSWX_OP_NONE) begin
			unsup <= 1'b1;
		end else if (wr_status && hwdata_i[SSWX_ST_UNSUP]) begin
			unsup <= 1'b0;
		end
	end

	// Operand stands in for the file register of bus-issued words
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			operand <= SSWX_OPERAND_RST;
		end else if (sel_bus && alu_to_file) begin
			operand <= alu_res; // [RULE1] [RULE6]
		end else if (wr_operand) begin
			operand <= hwdata_i[SSWX_DW-1:0];
		end
	end

	// Issue word and its pending bit; a fresh write re-arms even as one runs
	// Only the last word written runs if software writes twice before the
	// first one found a free cycle; nothing counts the lost word
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			issue_word <= SSWX_ISSUE_RST;
			issue_pend <= 1'b0;
		end else if (wr_issue) begin
			issue_word <= hwdata_i[SSWX_IW-1:0];
			issue_pend <= 1'b1;
		end else if (sel_bus) begin
			issue_pend <= 1'b0;
		end
	end

	// Last result with its destination, and a count of executed words
	// Unhandled words count too, so the count tracks done pulses one to one
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			result <= '0;
			count <= SSWX_CNT_RST;
		end else if (exec) begin
			result <= {alu_to_file, alu_res};
			count <= count + 1'b1;
		end
	end

	// File write-back lands one cycle after the decoder presents the word
	// Address and data hold between port words so that the core may sample
	// them late; only the strobe marks a fresh write
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			file_we_o <= 1'b0;
			file_addr_o <= '0;
			file_wdata_o <= '0;
			done_o <= 1'b0;
		end else begin
			file_we_o <= sel_port & alu_to_file; // [RULE1] [RULE6]
			done_o <= exec;
			if (sel_port) begin
				file_addr_o <= instr_i[SSWX_FADDR_HI:0];
				file_wdata_o <= alu_res;
			end
		end
	end

	// Flag view for the rest of the core
	// These mirror the flops directly, so a flag set at edge N is visible
	// to the core's branch logic in the very next cycle
	assign acc_o = acc;
	assign carry_o = carry;
	assign nibble_borrow_flag_o = nibble_flag;
	assign zero_o = zero;
endmodule : sswx_top
`default_nettype wire

// ---- verification/sswx_props.sv ----
// Checker of the datapath instruction results and flags
`timescale 1ns/1ps
`default_nettype none
module sswx_props
	import sswx_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic instr_valid_i,
	input wire logic [SSWX_IW-1:0] instr_i,
	input wire logic [SSWX_DW-1:0] file_rdata_i,
	input wire logic file_we_o,
	input wire logic [SSWX_FAW-1:0] file_addr_o,
	input wire logic [SSWX_DW-1:0] file_wdata_o,
	input wire logic [SSWX_DW-1:0] acc_o,
	input wire logic carry_o,
	input wire logic nibble_borrow_flag_o,
	input wire logic zero_o
);
	logic sub, swp, xr, dst, ge, nge, dz, xz;
	logic [7:0] dif, sw, xv;
	logic [6:0] fa;
	// Decoded views of the port word, so each property reads plainly
	assign sub = instr_valid_i && instr_i[13:8] == SSWX_OPC_SUB;
	assign swp = instr_valid_i && instr_i[13:8] == SSWX_OPC_SWAP;
	assign xr = instr_valid_i && instr_i[13:8] == SSWX_OPC_XOR;
	assign dst = instr_i[7];
	assign fa = instr_i[6:0];
	assign dif = file_rdata_i - acc_o;
	assign ge = file_rdata_i >= acc_o;
	assign nge = file_rdata_i[3:0] >= acc_o[3:0];
	assign dz = dif == 8'h00;
	assign sw = {file_rdata_i[3:0], file_rdata_i[7:4]};
	assign xv = acc_o ^ instr_i[7:0];
	assign xz = xv == 8'h00;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sub_acc_a: assert property (sub && !dst |=> acc_o == $past(dif) && !file_we_o)
		else $error("subtract into accumulator wrong");
	sub_file_a: assert property (sub && dst |=> file_we_o && file_wdata_o == $past(dif)
		&& file_addr_o == $past(fa) && $stable(acc_o)) else $error("subtract into file wrong");
	sub_flags_a: assert property (sub |=> carry_o == $past(ge)
		&& nibble_borrow_flag_o == $past(nge) && zero_o == $past(dz))
		else $error("subtract flags wrong");
	sub_zero_a: assert property (sub && dz |=> carry_o && zero_o)
		else $error("zero difference flags wrong");
	swap_res_a: assert property (swp |=>
		($past(dst) ? file_we_o && file_wdata_o == $past(sw) : acc_o == $past(sw)))
		else $error("nibble exchange result wrong");
	swap_flags_a: assert property (swp |=> $stable({carry_o, nibble_borrow_flag_o, zero_o}))
		else $error("nibble exchange touched flags");
	xor_acc_a: assert property (xr |=> acc_o == $past(xv) && !file_we_o)
		else $error("literal xor result wrong");
	xor_flags_a: assert property (xr |=> zero_o == $past(xz) && $stable(carry_o)
		&& $stable(nibble_borrow_flag_o)) else $error("literal xor flags wrong");
	cover property (sub && dz);
	cover property (swp && dst);
	cover property (xr && xz);
endmodule : sswx_props
bind sswx_top sswx_props u_sswx_props (.clk_i(clk_i), .rst_i(rst_i),
	.instr_valid_i(instr_valid_i), .instr_i(instr_i), .file_rdata_i(file_rdata_i),
	.file_we_o(file_we_o), .file_addr_o(file_addr_o), .file_wdata_o(file_wdata_o),
	.acc_o(acc_o), .carry_o(carry_o), .nibble_borrow_flag_o(nibble_borrow_flag_o),
	.zero_o(zero_o));
`default_nettype wire

// ---- verification/sswx_file_model.sv ----
// Behavioural file register array on the far side of the datapath
`timescale 1ns/1ps
`default_nettype none
module sswx_file_model
	import sswx_pkg::*;
(
	input wire logic clk_i,
	input wire logic [SSWX_FAW-1:0] raddr_i,
	output logic [SSWX_DW-1:0] rdata_o,
	input wire logic we_i,
	input wire logic [SSWX_FAW-1:0] waddr_i,
	input wire logic [SSWX_DW-1:0] wdata_i
);
	logic [SSWX_DW-1:0] mem [0:127];
	// Same-cycle read, as the decoder port expects
	assign rdata_o = mem[raddr_i];
	// Write-back lands at the edge that ends the pulse
	always @(posedge clk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
	end
endmodule : sswx_file_model
`default_nettype wire

// ---- verification/sswx_top_tb_top.sv ----
// Testbench of the datapath: bus and port sequences with expected values
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin check_count++; if ((e) !== (a)) begin fail_count++; \
	$display("MISMATCH %s exp %0h got %0h", n, e, a); end end
module sswx_top_tb_top
	import sswx_pkg::*;
;
	logic clk_i, rst_i, hsel_i, hwrite_i, instr_valid_i, we, hreadyout_o, hresp_o;
	logic carry_o, nib, zero_o, done_o;
	logic [31:0] haddr_i, hwdata_i, hrdata_o, q;
	logic [1:0] htrans_i;
	logic [13:0] instr_i;
	logic [7:0] rdata, wdata, acc_o;
	logic [6:0] waddr;
	int fail_count, check_count;
	sswx_top u_sswx_top (.clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
		.htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'b010), .hwdata_i(hwdata_i),
		.hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
		.hresp_o(hresp_o), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
		.file_rdata_i(rdata), .file_we_o(we), .file_addr_o(waddr), .file_wdata_o(wdata),
		.acc_o(acc_o), .carry_o(carry_o), .nibble_borrow_flag_o(nib), .zero_o(zero_o),
		.done_o(done_o));
	sswx_file_model u_sswx_file_model (.clk_i(clk_i), .raddr_i(instr_i[6:0]),
		.rdata_o(rdata), .we_i(we), .waddr_i(waddr), .wdata_i(wdata));
	// Verdict and end of run
	task test_done;
		if (fail_count == 0 && check_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : test_done
	// Bounded wait for hready; a hang ends the run as a failure
	task wait_rdy;
		for (int i = 0; i < 16; i++) begin
			@(posedge clk_i);
			if (hreadyout_o === 1'b1) return;
		end
		fail_count++;
		test_done();
	endtask : wait_rdy
	// One single AHB-Lite word transfer, read data taken at the data-phase edge
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge clk_i);
		hsel_i <= 1'b1;
		haddr_i <= {24'h000000, a};
		htrans_i <= SSWX_HTRANS_NONSEQ;
		hwrite_i <= wr;
		wait_rdy();
		htrans_i <= 2'b00;
		hsel_i <= 1'b0;
		hwdata_i <= d;
		wait_rdy();
		r = hrdata_o;
		`CHK("hresp", SSWX_HRESP_OKAY, hresp_o)
	endtask : bus
	// One port instruction; checks the chosen target and the flags {zero, nibble, carry}
	task run(input logic [13:0] w, input logic [7:0] f, r, input logic [2:0] fl);
		u_sswx_file_model.mem[w[6:0]] = f;
		@(posedge clk_i);
		instr_valid_i <= 1'b1;
		instr_i <= w;
		@(posedge clk_i);
		instr_valid_i <= 1'b0;
		@(negedge clk_i);
		`CHK("done", 1'b1, done_o)
		@(negedge clk_i);
		if (w[13:8] != 6'h3A && w[7]) `CHK("file", r, u_sswx_file_model.mem[w[6:0]])
		else `CHK("acc", r, acc_o)
		`CHK("flags", fl, {zero_o, nib, carry_o})
	endtask : run
	// Free-running 125 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	// Main sequence
	initial begin
		{rst_i, hsel_i, hwrite_i, instr_valid_i} = 4'hF - 4'h7;
		haddr_i = 32'h0;
		hwdata_i = 32'h0;
		htrans_i = 2'b00;
		instr_i = 14'h0000;
		fail_count = 0;
		check_count = 0;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		`CHK("acc reset", 8'h00, acc_o)
		bus(1'b1, SSWX_ACC_OFS, 32'h2, q);
		run(14'h0283, 8'h03, 8'h01, 3'b011);
		bus(1'b1, SSWX_ACC_OFS, 32'h2, q);
		run(14'h0285, 8'h02, 8'h00, 3'b111);
		bus(1'b1, SSWX_ACC_OFS, 32'h2, q);
		run(14'h0206, 8'h01, 8'hFF, 3'b000);
		bus(1'b1, SSWX_ACC_OFS, 32'h1, q);
		run(14'h0287, 8'h10, 8'h0F, 3'b001);
		run(14'h0E09, 8'hA5, 8'h5A, 3'b001);
		run(14'h0E8A, 8'h3C, 8'hC3, 3'b001);
		bus(1'b1, SSWX_ACC_OFS, 32'hB5, q);
		run(14'h3AAF, 8'h00, 8'h1A, 3'b001);
		run(14'h3A1A, 8'h00, 8'h00, 3'b101);
		bus(1'b0, SSWX_STATUS_OFS, 32'h0, q);
		`CHK("status", 32'h00000005, q)
		bus(1'b0, 8'h40, 32'h0, q);
		`CHK("unmapped", 32'h00000000, q)
		bus(1'b0, SSWX_ACC_OFS, 32'h0, q);
		`CHK("acc read", 32'h00000000, q)
		// Bus-issued subtract into the operand, then an unhandled port word
		bus(1'b1, SSWX_ACC_OFS, 32'h5, q);
		bus(1'b1, SSWX_OPERAND_OFS, 32'h7, q);
		bus(1'b1, SSWX_ISSUE_OFS, 32'h0280, q);
		bus(1'b0, SSWX_ISSUE_OFS, 32'h0, q);
		`CHK("issue read", 32'h00000280, q)
		bus(1'b0, SSWX_OPERAND_OFS, 32'h0, q);
		`CHK("operand", 32'h00000002, q)
		bus(1'b0, SSWX_RESULT_OFS, 32'h0, q);
		`CHK("result", 32'h00000102, q)
		bus(1'b0, SSWX_STATUS_OFS, 32'h0, q);
		`CHK("issue status", 32'h00000003, q)
		run(14'h0000, 8'h00, 8'h05, 3'b011);
		bus(1'b0, SSWX_STATUS_OFS, 32'h0, q);
		`CHK("unsup set", 32'h0000000B, q)
		bus(1'b1, SSWX_STATUS_OFS, 32'h0B, q);
		bus(1'b0, SSWX_STATUS_OFS, 32'h0, q);
		`CHK("unsup clear", 32'h00000003, q)
		bus(1'b0, SSWX_COUNT_OFS, 32'h0, q);
		`CHK("count", 32'h0000000A, q)
		test_done();
	end
endmodule : sswx_top_tb_top
`default_nettype wire
